// File: logic/dpl_pkg.sv
// shared constants and types for the dpll divider and loop configuration slice
// assumes a 32-bit apb slave where each documented byte register takes one word
package dpl_pkg;

    // register indices; byte address is four times the index
    localparam logic [8:0]  DPL_IDX_REF_PRESCALE  = 9'h103;
    localparam logic [8:0]  DPL_IDX_FB_DIV_LO     = 9'h104;
    localparam logic [8:0]  DPL_IDX_FB_DIV_HI     = 9'h105;
    localparam logic [8:0]  DPL_IDX_FB_PRESCALE   = 9'h106;
    localparam logic [8:0]  DPL_IDX_LOOP_RATE     = 9'h107;
    localparam logic [8:0]  DPL_IDX_C1_LIN_LO     = 9'h108;
    localparam logic [8:0]  DPL_IDX_C1_LIN_HI     = 9'h109;
    localparam logic [8:0]  DPL_IDX_C1_MULT       = 9'h10A;
    localparam logic [8:0]  DPL_IDX_C1_DIV        = 9'h10B;
    localparam logic [8:0]  DPL_IDX_C2_LIN_LO     = 9'h10C;
    localparam logic [8:0]  DPL_IDX_C2_LIN_HI     = 9'h10D;
    localparam logic [8:0]  DPL_IDX_C2_DIV        = 9'h10E;
    localparam logic [8:0]  DPL_IDX_C3_LIN_LO     = 9'h10F;
    localparam logic [8:0]  DPL_IDX_C3_LIN_HI     = 9'h110;
    localparam logic [8:0]  DPL_IDX_C3_DIV        = 9'h111;
    localparam logic [8:0]  DPL_IDX_RSV_FIRST     = 9'h112;
    localparam logic [8:0]  DPL_IDX_RSV_LAST      = 9'h114;
    localparam logic [8:0]  DPL_IDX_EST_FIRST     = 9'h115;
    localparam logic [8:0]  DPL_IDX_EST_LAST      = 9'h11A;

    localparam int          DPL_NUM_RW            = 15;
    localparam int          DPL_NUM_EST           = 6;
    localparam logic [7:0]  DPL_RESET_BYTE        = 8'h00;

    // writable bits per byte register; reserved bits store nothing, read zero
    localparam logic [7:0]  DPL_RW_MASK [0:DPL_NUM_RW-1] = '{
        8'h81, 8'hFF, 8'hFF, 8'h81, 8'h1F, 8'hFF, 8'h0F, 8'h1F,
        8'h07, 8'hFF, 8'h0F, 8'h07, 8'hFF, 8'h0F, 8'h07
    };

    // field positions inside the byte registers
    localparam int          DPL_BIT_PRESCALE      = 0;
    localparam int          DPL_BIT_INVERT        = 7;

    localparam int          DPL_LIN_W             = 12;
    localparam int          DPL_MULT_W            = 5;
    localparam int          DPL_DIV_W             = 3;
    localparam int          DPL_RATE_W            = 5;
    localparam int          DPL_RATE_CNT_W        = 31;
    localparam int          DPL_C1_EFF_W          = 43;
    localparam int          DPL_EST_W             = 48;

    typedef struct packed {
        logic        prescale;
        logic        invert;
        logic [15:0] value;
    } dpl_div_cfg_type;

    typedef struct packed {
        logic [DPL_LIN_W-1:0]    c1_linear;
        logic [DPL_MULT_W-1:0]   c1_mult_exp;
        logic [DPL_DIV_W-1:0]    c1_div_exp;
        logic [DPL_LIN_W-1:0]    c2_linear;
        logic [DPL_DIV_W-1:0]    c2_div_exp;
        logic [DPL_LIN_W-1:0]    c3_linear;
        logic [DPL_DIV_W-1:0]    c3_div_exp;
        logic [DPL_C1_EFF_W-1:0] c1_effective;
        logic [DPL_LIN_W-1:0]    c2_effective;
        logic [DPL_LIN_W-1:0]    c3_effective;
    } dpl_coef_type;

endpackage

// File: logic/dpl_edge_divider.sv
// edge-selectable clock divider with optional divide-by-two prescaler
// assumes clk_level is already synchronised to pclk
`timescale 1ns/1ps

module dpl_edge_divider (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // divided clock source and settings
    input  wire logic                     clk_level,
    input  wire dpl_pkg::dpl_div_cfg_type cfg,
    // one pulse per divided period
    output logic                          div_pulse
);
    import dpl_pkg::*;

    logic        prev_r;
    logic        half_r;
    logic [15:0] count_r;
    logic        pulse_r;

    wire rise_seen  = clk_level & ~prev_r;
    wire fall_seen  = ~clk_level & prev_r;
    wire edge_seen  = cfg.invert ? fall_seen : rise_seen;
    wire stage_step = cfg.prescale ? (edge_seen & half_r) : edge_seen;
    // a value lowered below the running count ends the period and restarts at the next stage_step
    wire count_end  = (count_r >= cfg.value);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 1'b0;
            half_r  <= 1'b0;
            count_r <= 16'h0000;
            pulse_r <= 1'b0;
        end else begin
            prev_r  <= clk_level;
            if (edge_seen && cfg.prescale) begin
                half_r <= ~half_r;
            end
            pulse_r <= stage_step & count_end;
            if (stage_step) begin
                count_r <= count_end ? 16'h0000 : count_r + 16'h0001;
            end
        end
    end

    assign div_pulse = pulse_r;

endmodule // dpl_edge_divider

// File: logic/dpl_divider_loop_config.sv
// apb register slice for dpll dividers, loop-filter rate and coefficients
// assumes apb from the same pclk domain; reference and feedback clocks are pins
//
// Behaviour
// RL1 - reference prescale bit adds divide-by-two ahead of the feedforward divider
// RL2 - software sets reference prescale above ratio 65,536 or inputs above 400 MHz
// RL3 - bit 7 of reference prescale register inverts reference clock before divider
// RL4 - feedback divider divides by stored 16-bit value plus one
// RL5 - lower feedback divider byte address holds the low eight bits
// RL6 - feedback prescale bit adds divide-by-two ahead of feedback divider
// RL7 - software sets feedback prescale above ratio 65,536 or input above 400 MHz
// RL8 - bit 7 of feedback prescale register inverts feedback clock before divider
// RL9 - loop filter ticks at system clock over two to the rate value
// RL10 - first coefficient: 12-bit linear, 5-bit multiplier and 3-bit divider exponents
// RL11 - second coefficient: 12-bit linear factor and 3-bit divider exponent
// RL12 - third coefficient: 12-bit linear factor and 3-bit divider exponent
// RL13 - 48-bit tuning word estimate is read-only; writes do nothing
// RL14 - feedforward divider divides by its 16-bit value plus one
// RL15 - effective coefficient is linear times two-power multiplier over two-power divider
`timescale 1ns/1ps

module dpl_divider_loop_config (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // reference and feedback pins
    input  wire logic                  reference_input_one,
    input  wire logic                  reference_input_two,
    input  wire logic                  feedback_clock_input,
    // datapath inputs on pclk
    input  wire logic                  ref_select,
    input  wire logic [15:0]           ff_divide_value,
    input  wire logic [47:0]           tuning_word_estimate,
    // datapath outputs
    output logic                       ref_div_pulse,
    output logic                       fb_div_pulse,
    output logic                       loop_rate_tick,
    output dpl_pkg::dpl_coef_type      coef
);
    import dpl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] ref_one_sync_r;
    logic [1:0] ref_two_sync_r;
    logic [1:0] fb_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_one_sync_r <= 2'h0;
            ref_two_sync_r <= 2'h0;
            fb_sync_r      <= 2'h0;
        end else begin
            ref_one_sync_r <= {ref_one_sync_r[0], reference_input_one};
            ref_two_sync_r <= {ref_two_sync_r[0], reference_input_two};
            fb_sync_r      <= {fb_sync_r[0], feedback_clock_input};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire [8:0]  acc_idx   = paddr[10:2];
    wire        word_ok   = (paddr[1:0] == 2'h0) & ~paddr[11];
    wire        hit_rw    = word_ok & (acc_idx >= DPL_IDX_REF_PRESCALE)
                                    & (acc_idx <= DPL_IDX_C3_DIV);
    wire        hit_rsv   = word_ok & (acc_idx >= DPL_IDX_RSV_FIRST)
                                    & (acc_idx <= DPL_IDX_RSV_LAST);
    wire        hit_est   = word_ok & (acc_idx >= DPL_IDX_EST_FIRST)
                                    & (acc_idx <= DPL_IDX_EST_LAST);
    wire        mapped    = hit_rw | hit_rsv | hit_est;
    wire [8:0]  rw_off    = acc_idx - DPL_IDX_REF_PRESCALE;
    wire [3:0]  rw_sel    = rw_off[3:0];
    wire [8:0]  est_off   = acc_idx - DPL_IDX_EST_FIRST;
    wire [47:0] est_shift = tuning_word_estimate >> {est_off[2:0], 3'h0};
    wire        setup_ph  = psel & ~penable;
    wire        access_ph = psel & penable;
    // the estimate never takes a write
    wire        wr_take   = access_ph & pwrite & hit_rw & pstrb[0]; // RL13

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // byte registers, one per word, reserved bits held at zero

    logic [7:0] cfg_r [0:DPL_NUM_RW-1];

    genvar gi;
    generate
        for (gi = 0; gi < DPL_NUM_RW; gi++) begin : g_byte
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[gi] <= DPL_RESET_BYTE;
                end else if (wr_take && (rw_sel == 4'(gi))) begin
                    cfg_r[gi] <= pwdata[7:0] & DPL_RW_MASK[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup phase so access needs no wait state

    wire [7:0] rw_byte  = cfg_r[rw_sel];
    wire [7:0] rd_byte  = hit_rw  ? rw_byte :
                          hit_est ? est_shift[7:0] : 8'h00; // RL13

    logic [31:0] prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    // only the slot number is computed here; the byte is read in each assignment
    // so that every field follows register writes
    function automatic int slot(input logic [8:0] idx);
        return int'(idx - DPL_IDX_REF_PRESCALE);
    endfunction

    wire [7:0] ref_ctl   = cfg_r[slot(DPL_IDX_REF_PRESCALE)];
    wire [7:0] fb_ctl    = cfg_r[slot(DPL_IDX_FB_PRESCALE)];
    // low byte address carries the low bits
    wire [15:0] fb_value = {cfg_r[slot(DPL_IDX_FB_DIV_HI)],
                            cfg_r[slot(DPL_IDX_FB_DIV_LO)]}; // RL5

    dpl_div_cfg_type ref_cfg;
    dpl_div_cfg_type fb_cfg;

    assign ref_cfg.prescale = ref_ctl[DPL_BIT_PRESCALE]; // RL1
    assign ref_cfg.invert   = ref_ctl[DPL_BIT_INVERT];   // RL3
    assign ref_cfg.value    = ff_divide_value;           // RL14
    assign fb_cfg.prescale  = fb_ctl[DPL_BIT_PRESCALE];  // RL6
    assign fb_cfg.invert    = fb_ctl[DPL_BIT_INVERT];    // RL8
    assign fb_cfg.value     = fb_value;                  // RL4

    ////////////////////////////////////////////////////////////////////////////
    // reference and feedback dividers

    wire ref_level = ref_select ? ref_two_sync_r[1] : ref_one_sync_r[1];

    dpl_edge_divider u_ref_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_level (ref_level),
        .cfg       (ref_cfg),
        .div_pulse (ref_div_pulse)
    ); // RL1 RL3 RL14

    dpl_edge_divider u_fb_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_level (fb_sync_r[1]),
        .cfg       (fb_cfg),
        .div_pulse (fb_div_pulse)
    ); // RL4 RL6 RL8

    ////////////////////////////////////////////////////////////////////////////
    // loop-filter rate enable

    wire [DPL_RATE_W-1:0]     rate_exp  = cfg_r[slot(DPL_IDX_LOOP_RATE)]
                                          [DPL_RATE_W-1:0];
    wire [DPL_RATE_CNT_W-1:0] rate_mask = ~({DPL_RATE_CNT_W{1'b1}} << rate_exp);

    logic [DPL_RATE_CNT_W-1:0] rate_cnt_r;
    logic                      rate_tick_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt_r  <= '0;
            rate_tick_r <= 1'b0;
        end else begin
            rate_cnt_r  <= rate_cnt_r + DPL_RATE_CNT_W'(1);
            rate_tick_r <= ((rate_cnt_r & rate_mask) == '0); // RL9
        end
    end

    assign loop_rate_tick = rate_tick_r;

    ////////////////////////////////////////////////////////////////////////////
    // loop coefficients

    wire [7:0] c1_lo = cfg_r[slot(DPL_IDX_C1_LIN_LO)];
    wire [7:0] c1_hi = cfg_r[slot(DPL_IDX_C1_LIN_HI)];
    wire [7:0] c2_lo = cfg_r[slot(DPL_IDX_C2_LIN_LO)];
    wire [7:0] c2_hi = cfg_r[slot(DPL_IDX_C2_LIN_HI)];
    wire [7:0] c3_lo = cfg_r[slot(DPL_IDX_C3_LIN_LO)];
    wire [7:0] c3_hi = cfg_r[slot(DPL_IDX_C3_LIN_HI)];

    dpl_coef_type coef_nxt;
    dpl_coef_type coef_r;

    assign coef_nxt.c1_linear   = {c1_hi[3:0], c1_lo};                        // RL10
    assign coef_nxt.c1_mult_exp = cfg_r[slot(DPL_IDX_C1_MULT)][DPL_MULT_W-1:0]; // RL10
    assign coef_nxt.c1_div_exp  = cfg_r[slot(DPL_IDX_C1_DIV)][DPL_DIV_W-1:0];   // RL10
    assign coef_nxt.c2_linear   = {c2_hi[3:0], c2_lo};                        // RL11
    assign coef_nxt.c2_div_exp  = cfg_r[slot(DPL_IDX_C2_DIV)][DPL_DIV_W-1:0];   // RL11
    assign coef_nxt.c3_linear   = {c3_hi[3:0], c3_lo};                        // RL12
    assign coef_nxt.c3_div_exp  = cfg_r[slot(DPL_IDX_C3_DIV)][DPL_DIV_W-1:0];   // RL12

    wire [DPL_C1_EFF_W-1:0] c1_wide = DPL_C1_EFF_W'(coef_nxt.c1_linear);

    assign coef_nxt.c1_effective = (c1_wide << coef_nxt.c1_mult_exp)
                                   >> coef_nxt.c1_div_exp;            // RL15
    assign coef_nxt.c2_effective = coef_nxt.c2_linear >> coef_nxt.c2_div_exp; // RL15
    assign coef_nxt.c3_effective = coef_nxt.c3_linear >> coef_nxt.c3_div_exp; // RL15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef_r <= '0;
        end else begin
            coef_r <= coef_nxt;
        end
    end

    assign coef = coef_r;

endmodule // dpl_divider_loop_config

// File: verif/dpl_divider_loop_config_properties.sv
// concurrent checks on the ports of the dpll divider and loop configuration slice
// assumes zero-wait apb with byte registers at four times their index
`timescale 1ns/1ps

module dpl_divider_loop_config_chk (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // apb slave
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    // datapath
    input wire logic [47:0]           tuning_word_estimate,
    input wire logic                  ref_div_pulse,
    input wire logic                  fb_div_pulse,
    input wire dpl_pkg::dpl_coef_type coef
);
    import dpl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_setup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_wr_access(a);
        psel && penable && pwrite && pstrb[0] && paddr == a;
    endsequence

    property p_c1_eff;
        coef.c1_effective == ((43'(coef.c1_linear) << coef.c1_mult_exp) >> coef.c1_div_exp);
    endproperty
    property p_c2_eff;
        coef.c2_effective == (coef.c2_linear >> coef.c2_div_exp);
    endproperty
    property p_c3_eff;
        coef.c3_effective == (coef.c3_linear >> coef.c3_div_exp);
    endproperty
    property p_c1_write;
        s_wr_access(12'h420) |-> ##2 coef.c1_linear[7:0] == $past(pwdata[7:0], 2);
    endproperty
    property p_est_read;
        s_rd_setup(12'h454) |=> prdata == {24'h000000, $past(tuning_word_estimate[7:0])};
    endproperty
    property p_est_quiet;
        psel && penable && paddr inside {[12'h454:12'h468]} && paddr[1:0] == 2'b00
            |-> pready && !pslverr;
    endproperty
    property p_misalign;
        psel && penable && paddr[1:0] != 2'b00 |-> pready && pslverr;
    endproperty
    property p_ref_single;
        ref_div_pulse |=> !ref_div_pulse;
    endproperty
    property p_fb_single;
        fb_div_pulse |=> !fb_div_pulse;
    endproperty

    a_c1_eff: assert property (p_c1_eff)
        else $error("first coefficient product wrong");
    a_c2_eff: assert property (p_c2_eff)
        else $error("second coefficient quotient wrong");
    a_c3_eff: assert property (p_c3_eff)
        else $error("third coefficient quotient wrong");
    a_c1_write: assert property (p_c1_write)
        else $error("first coefficient low byte not taken");
    a_est_read: assert property (p_est_read)
        else $error("estimate low byte read wrong");
    a_est_quiet: assert property (p_est_quiet)
        else $error("estimate area access flagged");
    a_misalign: assert property (p_misalign)
        else $error("misaligned access not refused");
    a_ref_single: assert property (p_ref_single)
        else $error("reference pulse longer than one cycle");
    a_fb_single: assert property (p_fb_single)
        else $error("feedback pulse longer than one cycle");
endmodule // dpl_divider_loop_config_chk

bind dpl_divider_loop_config dpl_divider_loop_config_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tuning_word_estimate(tuning_word_estimate),
    .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse), .coef(coef)
);

// File: verif/dpl_divider_loop_config_tb_top.sv
// self-checking bench for the dpll divider and loop configuration slice
// assumes a zero-wait apb slave and byte registers at four times their index
`timescale 1ns/1ps

module dpl_divider_loop_config_tb_top;
    import dpl_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [3:0]   pstrb = 4'h0;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    logic         reference_input_one = 1'b0;
    logic         reference_input_two = 1'b0;
    logic         feedback_clock_input = 1'b0;
    logic         ref_select = 1'b0;
    logic [15:0]  ff_divide_value = 16'h0;
    logic [47:0]  tuning_word_estimate = 48'h0;
    logic         ref_div_pulse;
    logic         fb_div_pulse;
    logic         loop_rate_tick;
    dpl_coef_type coef;
    logic [7:0]   regm [0:DPL_NUM_RW-1];
    logic [32:0]  expq [$];
    int           num_errors = 0;
    int           total_checks = 0;

    always #2.5 pclk = ~pclk;

    dpl_divider_loop_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reference_input_one(reference_input_one), .reference_input_two(reference_input_two),
        .feedback_clock_input(feedback_clock_input), .ref_select(ref_select),
        .ff_divide_value(ff_divide_value), .tuning_word_estimate(tuning_word_estimate),
        .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
        .loop_rate_tick(loop_rate_tick), .coef(coef));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (expq.size() != 0) begin
            num_errors++;
            $display("[ERR] %0t %0d reads never answered", $time, expq.size());
        end
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp_val(input logic [47:0] e, input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_rd(input logic [32:0] e);
        total_checks++;
        if ({pslverr, prdata} !== e) begin
            num_errors++;
            $display("[ERR] %0t read %h expected %h", $time, {pslverr, prdata}, e);
        end
    endtask

    // byte address of the register i places above the reference prescale register
    function automatic logic [11:0] ad(input int i);
        return {1'b0, DPL_IDX_REF_PRESCALE + 9'(i), 2'b00};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t no ready", $time);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        apb(1'b1, ad(i), d, 4'hF);
    endtask

    task automatic rd(input logic [11:0] a, input logic e, input logic [7:0] d);
        expq.push_back({e, 24'h0, d});
        apb(1'b0, a, 8'h00, 4'h0);
    endtask

    // drives one pin high then low n times, counting pulses after its rising and falling edges
    task automatic run_pins(input int path, input int n, input int eh, input int el);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        repeat (n) begin
            for (int ph = 1; ph >= 0; ph--) begin
                if (path == 2) feedback_clock_input <= ph[0];
                else if (path == 1) reference_input_two <= ph[0];
                else reference_input_one <= ph[0];
                // pins run far below the rate and ratio that call for the prescaler
                repeat (8) begin
                    @(posedge pclk);
                    if ((path == 2 ? fb_div_pulse : ref_div_pulse) === 1'b1) begin
                        if (ph == 1) hi++;
                        else lo++;
                    end
                end
            end
        end
        cmp_val(48'(eh), 48'(hi));
        cmp_val(48'(el), 48'(lo));
    endtask

    // read results are matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) cmp_rd(expq.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic [11:0] l1, l2, l3;
        void'($urandom(32'hDA6D3CBA));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 18; i++) rd(ad(i), 1'b0, 8'h00);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < DPL_NUM_RW; i++) begin
                regm[i] = 8'($urandom);
                wr(i, regm[i]);
                apb(1'b1, ad(i), ~regm[i], 4'hE);
                regm[i] &= DPL_RW_MASK[i];
                rd(ad(i), 1'b0, regm[i]);
            end
            l1 = {regm[6][3:0], regm[5]};
            l2 = {regm[10][3:0], regm[9]};
            l3 = {regm[13][3:0], regm[12]};
            cmp_val(48'(coef.c1_linear), 48'(l1));
            cmp_val(48'(coef.c1_mult_exp), 48'(regm[7][4:0]));
            cmp_val(48'(coef.c1_div_exp), 48'(regm[8][2:0]));
            cmp_val(48'(coef.c1_effective), 48'((43'(l1) << regm[7][4:0]) >> regm[8][2:0]));
            cmp_val(48'(coef.c2_linear), 48'(l2));
            cmp_val(48'(coef.c2_effective), 48'(l2 >> regm[11][2:0]));
            cmp_val(48'(coef.c3_linear), 48'(l3));
            cmp_val(48'(coef.c3_effective), 48'(l3 >> regm[14][2:0]));
        end
        tuning_word_estimate <= {16'($urandom), 32'($urandom)};
        wr(15, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            wr(18 + i, 8'($urandom));
            rd(ad(18 + i), 1'b0, tuning_word_estimate[8*i +: 8]);
        end
        rd(ad(15), 1'b0, 8'h00);
        rd(ad(-1), 1'b1, 8'h00);
        rd(ad(24), 1'b1, 8'h00);
        rd(ad(0) + 12'h001, 1'b1, 8'h00);
        rd(ad(0) | 12'h800, 1'b1, 8'h00);
        for (int e = 0; e < 6; e++) begin
            wr(4, 8'hE0 | 8'(e));
            repeat (4) @(posedge pclk);
            n = 0;
            repeat (64) begin
                @(posedge pclk);
                if (loop_rate_tick === 1'b1) n++;
            end
            cmp_val(48'(64 >> e), 48'(n));
        end
        wr(3, 8'h00);
        wr(1, 8'h01);
        wr(2, 8'h00);
        run_pins(2, 4, 2, 0);
        wr(1, 8'h00);
        wr(2, 8'h01);
        run_pins(2, 257, 1, 0);
        wr(2, 8'h00);
        wr(3, 8'h01);
        run_pins(2, 6, 3, 0);
        wr(3, 8'h80);
        run_pins(2, 3, 0, 3);
        ff_divide_value <= 16'h0002;
        wr(0, 8'h00);
        run_pins(0, 6, 2, 0);
        run_pins(1, 6, 0, 0);
        ref_select <= 1'b1;
        ff_divide_value <= 16'h0000;
        wr(0, 8'h01);
        run_pins(1, 6, 3, 0);
        wr(0, 8'h80);
        run_pins(1, 3, 0, 3);
        complete_run();
    end
endmodule // dpl_divider_loop_config_tb_top
